// *** dmbr_consts.svh ***
// constants for the drive monitor and broadcast register bank
// assumes 16-bit register words addressed by a 16-bit register number
`ifndef DMBR_CONSTS_SVH
`define DMBR_CONSTS_SVH

`define DMBR_ADDR_RUN_CMD      16'h0001
`define DMBR_ADDR_SPEED_REF    16'h0002
`define DMBR_ADDR_TERM_IN      16'h002b
`define DMBR_ADDR_DRIVE_STAT   16'h002c
`define DMBR_ADDR_DOUT_STAT    16'h002d
`define DMBR_ADDR_DC_BUS       16'h0031
`define DMBR_ADDR_PCT_U        16'h0038
`define DMBR_ADDR_PCT_SA       16'h0039
`define DMBR_ADDR_PCT_SB       16'h003a
`define DMBR_ADDR_CPU_FW       16'h003b
`define DMBR_ADDR_FLASH_FW     16'h003c
`define DMBR_ADDR_LINK_ERR     16'h003d
`define DMBR_ADDR_POWER        16'h003e
`define DMBR_ADDR_CTRL_METHOD  16'h003f
`define DMBR_BCAST_SLAVE       8'h00
`define DMBR_RUN_FWD_BIT       0
`define DMBR_RUN_REV_BIT       1
`define DMBR_RUN_EXTF_BIT      4
`define DMBR_RUN_FRST_BIT      5
`define DMBR_RUN_TERM_LSB      12
`define DMBR_TERM5_IDX         4
`define DMBR_STAT_RUN_BIT      0
`define DMBR_STAT_ZSPD_BIT     1
`define DMBR_STAT_FAGREE_BIT   2
`define DMBR_STAT_UAGREE_BIT   3
`define DMBR_STAT_FLE_BIT      4
`define DMBR_STAT_FGE_BIT      5
`define DMBR_STAT_START_BIT    6
`define DMBR_STAT_UV_BIT       7
`define DMBR_STAT_BLOCK_BIT    8
`define DMBR_STAT_REFSRC_BIT   9
`define DMBR_STAT_OVTQ_BIT     11
`define DMBR_STAT_REFLOST_BIT  12
`define DMBR_STAT_RESTART_BIT  13
`define DMBR_STAT_FAULT_BIT    14
`define DMBR_STAT_TMO_BIT      15
`define DMBR_ERR_CRC_BIT       0
`define DMBR_ERR_LEN_BIT       1
`define DMBR_ERR_PAR_BIT       3
`define DMBR_ERR_OVR_BIT       4
`define DMBR_ERR_FRM_BIT       5
`define DMBR_ERR_TMO_BIT       6
`define DMBR_CODE_OK           8'h00
`define DMBR_CODE_BAD_ADDR     8'h02
`define DMBR_CODE_WRITE_MODE   8'h22
`define DMBR_WORD_ZERO         16'h0000

`endif

// *** dmbr_master.sv ***
// bus master model: one register access per call
// assumes the bank takes a request at one edge and answers the next cycle
`timescale 1ns/1ns
module dmbr_master
    import dmbr_pkg::*;
(
    input  wire logic                 clk,
    output      dmbr_pkg::dmbr_req_s  req,
    input  wire dmbr_pkg::dmbr_resp_s resp
);
    initial req = '0;
    // ==========
    // access task; gap idles first to model a slow master
    task automatic xfer(input logic w, input logic [7:0] slave, input logic [15:0] addr,
                        input logic [15:0] data, input int gap, output dmbr_resp_s r);
        repeat (gap) @(posedge clk);
        @(posedge clk);
        req <= '{valid: 1'b1, write: w, slave: slave, addr: addr, wdata: data};
        @(posedge clk);
        // idle fields show stale inverse so nothing leans on them
        req <= '{valid: 1'b0, write: ~w, slave: ~slave, addr: ~addr, wdata: ~data};
        #1 r = resp;
    endtask
endmodule

// *** dmbr_pkg.sv ***
// types shared by the drive monitor and broadcast register bank
// assumes dmbr_consts.svh supplies all numeric constants
package dmbr_pkg;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [7:0]  slave;
        logic [15:0] addr;
        logic [15:0] wdata;
    } dmbr_req_s;

    typedef struct packed {
        logic        valid;
        logic        error;
        logic [7:0]  code;
        logic [15:0] rdata;
    } dmbr_resp_s;

    typedef struct packed {
        logic operating;
        logic zero_speed;
        logic freq_agree;
        logic user_speed_agree;
        logic startup_done;
        logic undervoltage;
        logic baseblock;
        logic ref_from_comm;
        logic overtorque;
        logic ref_lost;
        logic restarting;
        logic any_fault;
        logic comm_timeout;
    } dmbr_drive_s;

    typedef struct packed {
        logic crc;
        logic length;
        logic parity;
        logic overrun;
        logic framing;
        logic timeout;
    } dmbr_link_err_s;

    typedef struct packed {
        logic       forward_run;
        logic       reverse_run;
        logic       external_fault;
        logic       fault_reset;
        logic [2:0] input_terminal_5_7;
    } dmbr_run_s;

endpackage

// *** dmbr_regs.sv ***
// drive monitor and broadcast register bank: read-only monitor words,
// sticky link error details and the writable broadcast run/speed words
// assumes a message decoder outside that has already checked framing and
// CRC and hands over one register access per request, all on clk
`timescale 1ns/1ns
`include "dmbr_consts.svh"

// Function
// - input status word bits 0..6 mirror input terminals 1..7, upper bits zero
// - status bits 0..3: operating, zero speed, frequency agree, user speed agree
// - bit 4 when output frequency <= detect level, bit 5 when >= it
// - bit 6 startup done, bit 7 undervoltage, bit 8 baseblock
// - bit 9 reads 0 for reference from comm option, else 1
// - bit B overtorque, bit C reference lost, bit D restarting
// - bit E any fault including comm time-out; bit F comm time-out
// - output status bits 0..2 mirror the three digital outputs
// - first percent monitor reported unsigned, 0.1 percent per lsb
// - second and third percent monitors reported signed, same scaling
// - link error bits latch until a fault reset, even while running
// - broadcast messages are accepted and acted on with no response
// - run word: fwd bit 0, rev bit 1, ext fault bit 4, reset bit 5
// - broadcast bits C..E rise to 1 only when locally enabled
// - undefined broadcast bits leave local terminal signals in use
module dmbr_regs #(
    parameter int DATA_W = 16
) (
    input  wire logic                    clk,
    input  wire logic                    reset,
    input  wire dmbr_pkg::dmbr_req_s     req,
    output      dmbr_pkg::dmbr_resp_s    resp,
    input  wire logic [6:0]              input_terminal,
    input  wire logic [2:0]              digital_output,
    input  wire dmbr_pkg::dmbr_drive_s   drive,
    input  wire logic [DATA_W-1:0]       output_frequency,
    input  wire logic [DATA_W-1:0]       frequency_detect_level,
    input  wire logic [DATA_W-1:0]       dc_bus_voltage,
    input  wire logic [DATA_W-1:0]       percent_unsigned,
    input  wire logic signed [DATA_W-1:0] percent_signed_a,
    input  wire logic signed [DATA_W-1:0] percent_signed_b,
    input  wire logic [DATA_W-1:0]       cpu_firmware,
    input  wire logic [DATA_W-1:0]       flash_firmware,
    input  wire logic [DATA_W-1:0]       power_rating,
    input  wire logic [DATA_W-1:0]       control_method,
    input  wire dmbr_pkg::dmbr_link_err_s link_err_event,
    input  wire logic                    local_fault_reset,
    input  wire logic [2:0]              terminal_enable,
    output      dmbr_pkg::dmbr_run_s     run,
    output      logic [DATA_W-1:0]       speed_reference,
    output      logic                    speed_reference_valid,
    output      logic [DATA_W-1:0]       link_error_details
);
    import dmbr_pkg::*;

    // ==========================================================
    // request decode
    // ==========================================================
    logic            is_bcast;
    logic            is_bcast_reg;
    logic            is_monitor;
    logic            wr_run;
    logic            wr_speed;
    logic            fault_reset_evt;
    logic [DATA_W-1:0] drive_word;
    logic [DATA_W-1:0] term_word;
    logic [DATA_W-1:0] dout_word;
    logic [DATA_W-1:0] err_word;
    logic [DATA_W-1:0] read_word;
    logic            freq_at_or_below;
    logic            freq_at_or_above;

    assign is_bcast = (req.slave == `DMBR_BCAST_SLAVE);

    assign is_bcast_reg = (req.addr == `DMBR_ADDR_RUN_CMD)
                       || (req.addr == `DMBR_ADDR_SPEED_REF);

    always_comb
    begin
        case (req.addr)
            `DMBR_ADDR_TERM_IN,
            `DMBR_ADDR_DRIVE_STAT,
            `DMBR_ADDR_DOUT_STAT,
            `DMBR_ADDR_DC_BUS,
            `DMBR_ADDR_PCT_U,
            `DMBR_ADDR_PCT_SA,
            `DMBR_ADDR_PCT_SB,
            `DMBR_ADDR_CPU_FW,
            `DMBR_ADDR_FLASH_FW,
            `DMBR_ADDR_LINK_ERR,
            `DMBR_ADDR_POWER,
            `DMBR_ADDR_CTRL_METHOD:
                is_monitor = 1'b1;
            default:
                is_monitor = 1'b0;
        endcase
    end

    // broadcast and directed writes both land on the run and speed words
    assign wr_run   = req.valid && req.write
                   && (req.addr == `DMBR_ADDR_RUN_CMD);
    assign wr_speed = req.valid && req.write
                   && (req.addr == `DMBR_ADDR_SPEED_REF);

    assign fault_reset_evt = local_fault_reset
                          || (wr_run && req.wdata[`DMBR_RUN_FRST_BIT]);

    // ==========================================================
    // monitor word assembly
    // ==========================================================
    assign freq_at_or_below = (output_frequency <= frequency_detect_level);
    assign freq_at_or_above = (output_frequency >= frequency_detect_level);

    always_comb
    begin
        term_word      = '0;
        term_word[6:0] = input_terminal;
    end

    always_comb
    begin
        dout_word      = '0;
        dout_word[2:0] = digital_output;
    end

    always_comb
    begin
        drive_word     = '0;
        drive_word[`DMBR_STAT_RUN_BIT]     = drive.operating;
        drive_word[`DMBR_STAT_ZSPD_BIT]    = drive.zero_speed;
        drive_word[`DMBR_STAT_FAGREE_BIT]  = drive.freq_agree;
        drive_word[`DMBR_STAT_UAGREE_BIT]  = drive.user_speed_agree;
        drive_word[`DMBR_STAT_FLE_BIT]     = freq_at_or_below;
        drive_word[`DMBR_STAT_FGE_BIT]     = freq_at_or_above;
        drive_word[`DMBR_STAT_START_BIT]   = drive.startup_done;
        drive_word[`DMBR_STAT_UV_BIT]      = drive.undervoltage;
        drive_word[`DMBR_STAT_BLOCK_BIT]   = drive.baseblock;
        drive_word[`DMBR_STAT_REFSRC_BIT]  = ~drive.ref_from_comm;
        drive_word[`DMBR_STAT_OVTQ_BIT]    = drive.overtorque;
        drive_word[`DMBR_STAT_REFLOST_BIT] = drive.ref_lost;
        drive_word[`DMBR_STAT_RESTART_BIT] = drive.restarting;
        drive_word[`DMBR_STAT_FAULT_BIT]   = drive.any_fault || drive.comm_timeout;
        drive_word[`DMBR_STAT_TMO_BIT]     = drive.comm_timeout;
    end

    always_comb
    begin
        err_word = link_error_details;
    end

    always_comb
    begin
        case (req.addr)
            `DMBR_ADDR_TERM_IN:     read_word = term_word;
            `DMBR_ADDR_DRIVE_STAT:  read_word = drive_word;
            `DMBR_ADDR_DOUT_STAT:   read_word = dout_word;
            `DMBR_ADDR_DC_BUS:      read_word = dc_bus_voltage;
            `DMBR_ADDR_PCT_U:       read_word = percent_unsigned;
            `DMBR_ADDR_PCT_SA:      read_word = percent_signed_a;
            `DMBR_ADDR_PCT_SB:      read_word = percent_signed_b;
            `DMBR_ADDR_CPU_FW:      read_word = cpu_firmware;
            `DMBR_ADDR_FLASH_FW:    read_word = flash_firmware;
            `DMBR_ADDR_LINK_ERR:    read_word = err_word;
            `DMBR_ADDR_POWER:       read_word = power_rating;
            `DMBR_ADDR_CTRL_METHOD: read_word = control_method;
            default:                read_word = `DMBR_WORD_ZERO;
        endcase
    end

    // ==========================================================
    // sticky link error details
    // ==========================================================
    // a new error in the fault reset cycle must survive, so set beats clear
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            link_error_details <= `DMBR_WORD_ZERO;
        end
        else
        begin
            if (fault_reset_evt)
            begin
                link_error_details <= `DMBR_WORD_ZERO;
            end
            if (link_err_event.crc)
                link_error_details[`DMBR_ERR_CRC_BIT] <= 1'b1;
            if (link_err_event.length)
                link_error_details[`DMBR_ERR_LEN_BIT] <= 1'b1;
            if (link_err_event.parity)
                link_error_details[`DMBR_ERR_PAR_BIT] <= 1'b1;
            if (link_err_event.overrun)
                link_error_details[`DMBR_ERR_OVR_BIT] <= 1'b1;
            if (link_err_event.framing)
                link_error_details[`DMBR_ERR_FRM_BIT] <= 1'b1;
            if (link_err_event.timeout)
                link_error_details[`DMBR_ERR_TMO_BIT] <= 1'b1;
        end
    end

    // ==========================================================
    // broadcast run command
    // ==========================================================
    logic [2:0] bcast_term;

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            run.forward_run    <= 1'b0;
            run.reverse_run    <= 1'b0;
            run.external_fault <= 1'b0;
        end
        else if (wr_run)
        begin
            run.forward_run    <= req.wdata[`DMBR_RUN_FWD_BIT];
            run.reverse_run    <= req.wdata[`DMBR_RUN_REV_BIT];
            run.external_fault <= req.wdata[`DMBR_RUN_EXTF_BIT];
        end
    end

    // fault reset is an action, not a level: one cycle per write
    always_ff @(posedge clk)
    begin
        if (reset)
            run.fault_reset <= 1'b0;
        else
            run.fault_reset <= wr_run && req.wdata[`DMBR_RUN_FRST_BIT];
    end

    genvar gi;
    generate
        for (gi = 0; gi < $bits(terminal_enable); gi++)
        begin : g_term
            // a rise is only taken while the local enable allows it
            always_ff @(posedge clk)
            begin
                if (reset)
                    bcast_term[gi] <= 1'b0;
                else if (wr_run)
                begin
                    if (!req.wdata[`DMBR_RUN_TERM_LSB + gi])
                        bcast_term[gi] <= 1'b0;
                    else if (terminal_enable[gi])
                        bcast_term[gi] <= 1'b1;
                end
            end

            // without the enable the local terminal keeps control
            always_ff @(posedge clk)
            begin
                if (reset)
                    run.input_terminal_5_7[gi] <= 1'b0;
                else if (terminal_enable[gi])
                    run.input_terminal_5_7[gi] <= bcast_term[gi];
                else
                    run.input_terminal_5_7[gi] <= input_terminal[`DMBR_TERM5_IDX + gi];
            end
        end
    endgenerate

    // ==========================================================
    // broadcast speed reference
    // ==========================================================
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            speed_reference       <= `DMBR_WORD_ZERO;
            speed_reference_valid <= 1'b0;
        end
        else if (wr_speed)
        begin
            speed_reference       <= req.wdata;
            speed_reference_valid <= 1'b1;
        end
    end

    // ==========================================================
    // response
    // ==========================================================
    // broadcasts stay silent, even when they name a bad register
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            resp <= '0;
        end
        else
        begin
            resp.valid <= req.valid && !is_bcast;
            resp.error <= 1'b0;
            resp.code  <= `DMBR_CODE_OK;
            resp.rdata <= `DMBR_WORD_ZERO;
            if (req.valid && !is_bcast)
            begin
                if (!req.write)
                begin
                    resp.rdata <= read_word;
                end
                else if (is_monitor)
                begin
                    resp.error <= 1'b1;
                    resp.code  <= `DMBR_CODE_WRITE_MODE;
                end
                else if (!is_bcast_reg)
                begin
                    resp.error <= 1'b1;
                    resp.code  <= `DMBR_CODE_BAD_ADDR;
                end
            end
        end
    end

endmodule

// *** dmbr_regs_sva.sv ***
// checker for the drive monitor and broadcast register bank
// assumes it sees only the ports of dmbr_regs, all on clk
`timescale 1ns/1ns
`include "dmbr_consts.svh"
module dmbr_regs_sva
    import dmbr_pkg::*;
#(
    parameter int DATA_W = 16
) (
    input wire logic                     clk,
    input wire logic                     reset,
    input wire dmbr_pkg::dmbr_req_s      req,
    input wire dmbr_pkg::dmbr_resp_s     resp,
    input wire logic [6:0]               input_terminal,
    input wire logic [2:0]               digital_output,
    input wire logic [DATA_W-1:0]        output_frequency,
    input wire logic [DATA_W-1:0]        frequency_detect_level,
    input wire dmbr_pkg::dmbr_link_err_s link_err_event,
    input wire logic                     local_fault_reset,
    input wire dmbr_pkg::dmbr_run_s      run,
    input wire logic [DATA_W-1:0]        speed_reference,
    input wire logic                     speed_reference_valid,
    input wire logic [DATA_W-1:0]        link_error_details
);
    // ==========
    // helpers
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    logic rd_dir;
    logic run_wr;
    assign rd_dir = req.valid && !req.write && req.slave != `DMBR_BCAST_SLAVE;
    assign run_wr = req.valid && req.write && req.addr == `DMBR_ADDR_RUN_CMD;
    // ==========
    // assertions
    a_bcast_silent: assert property (req.valid && req.slave == 8'h00 |=> !resp.valid)
        else $error("broadcast answered");
    a_term_mirror: assert property (rd_dir && req.addr == `DMBR_ADDR_TERM_IN |=>
        resp.valid && resp.rdata == {9'h000, $past(input_terminal)})
        else $error("input status word wrong");
    a_freq_detect: assert property (rd_dir && req.addr == `DMBR_ADDR_DRIVE_STAT |=>
        resp.rdata[5:4] == {$past(output_frequency) >= $past(frequency_detect_level),
                            $past(output_frequency) <= $past(frequency_detect_level)})
        else $error("frequency detect bits wrong");
    a_dout_mirror: assert property (rd_dir && req.addr == `DMBR_ADDR_DOUT_STAT |=>
        resp.rdata == {13'h0000, $past(digital_output)})
        else $error("output status word wrong");
    a_ro_reject: assert property (req.valid && req.write && req.slave != 8'h00 &&
        (req.addr == `DMBR_ADDR_DRIVE_STAT || req.addr == `DMBR_ADDR_TERM_IN)
        |=> resp.error && resp.code == 8'h22)
        else $error("monitor write not refused");
    a_err_set: assert property (link_err_event.timeout |=> link_error_details[6])
        else $error("timeout flag not latched");
    a_err_hold: assert property (link_error_details[0] && !local_fault_reset &&
        !(run_wr && req.wdata[5]) |=> link_error_details[0])
        else $error("crc flag lost without reset");
    a_run_decode: assert property (run_wr |=> run.forward_run == $past(req.wdata[0]) &&
        run.reverse_run == $past(req.wdata[1]) && run.external_fault == $past(req.wdata[4])
        && run.fault_reset == $past(req.wdata[5]))
        else $error("run word decode wrong");
    a_speed_load: assert property (req.valid && req.write &&
        req.addr == `DMBR_ADDR_SPEED_REF |=> speed_reference == $past(req.wdata)
        && speed_reference_valid)
        else $error("speed reference not loaded");
    a_unused_zero: assert property (rd_dir && req.addr == `DMBR_ADDR_LINK_ERR |=>
        resp.rdata[15:7] == 9'h000 && !resp.rdata[2])
        else $error("unused error bits set");
    c_bcast_run: cover property (run_wr && req.slave == 8'h00);
    c_stat_read: cover property (rd_dir && req.addr == `DMBR_ADDR_DRIVE_STAT);
    c_err_clear: cover property (local_fault_reset && link_error_details != 16'h0000);
endmodule

bind dmbr_regs dmbr_regs_sva #(.DATA_W(DATA_W)) u_sva (.clk, .reset, .req, .resp,
    .input_terminal, .digital_output, .output_frequency, .frequency_detect_level,
    .link_err_event, .local_fault_reset, .run, .speed_reference, .speed_reference_valid,
    .link_error_details);

// *** dmbr_regs_test.sv ***
// self-checking bench for the monitor and broadcast register bank
// assumes dmbr_master issues accesses and the checker is bound in
`timescale 1ns/1ns
`include "dmbr_consts.svh"
module dmbr_regs_test;
    import dmbr_pkg::*;
    logic clk;
    logic reset = 1'b1;
    dmbr_req_s req;
    dmbr_resp_s resp;
    dmbr_resp_s r;
    logic [6:0] input_terminal = 7'h55;
    logic [2:0] digital_output = 3'b101;
    dmbr_drive_s drive = '0;
    logic [15:0] output_frequency = 16'h0000;
    logic [15:0] frequency_detect_level = 16'h000a;
    logic [15:0] dc_bus_voltage = 16'h0101;
    logic [15:0] percent_unsigned = 16'h03e8;
    logic signed [15:0] percent_signed_a = 16'hfc18;
    logic signed [15:0] percent_signed_b = 16'h8000;
    logic [15:0] cpu_firmware = 16'h1111;
    logic [15:0] flash_firmware = 16'h2222;
    logic [15:0] power_rating = 16'h0033;
    logic [15:0] control_method = 16'h0004;
    dmbr_link_err_s link_err_event = '0;
    logic local_fault_reset = 1'b0;
    logic [2:0] terminal_enable = 3'b000;
    dmbr_run_s run;
    logic [15:0] speed_reference;
    logic speed_reference_valid;
    logic [15:0] link_error_details;
    int failures = 0;
    int n_compared = 0;
    int stat_bit [13] = '{0, 1, 2, 3, 6, 7, 8, 9, 11, 12, 13, 14, 15};
    logic [15:0] freq [3] = '{16'h0009, 16'h000a, 16'h000b};
    logic [15:0] fexp [3] = '{16'h0210, 16'h0230, 16'h0220};
    logic [15:0] mon_addr [8] = '{16'h0031, 16'h0038, 16'h0039, 16'h003a, 16'h003b,
                                  16'h003c, 16'h003e, 16'h003f};
    logic [15:0] mon_val [8] = '{16'h0101, 16'h03e8, 16'hfc18, 16'h8000, 16'h1111,
                                 16'h2222, 16'h0033, 16'h0004};
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    dmbr_master master (.clk, .req, .resp);
    dmbr_regs #(.DATA_W(16)) dut (.clk, .reset, .req, .resp, .input_terminal,
        .digital_output, .drive, .output_frequency, .frequency_detect_level,
        .dc_bus_voltage, .percent_unsigned, .percent_signed_a, .percent_signed_b,
        .cpu_firmware, .flash_firmware, .power_rating, .control_method, .link_err_event,
        .local_fault_reset, .terminal_enable, .run, .speed_reference,
        .speed_reference_valid, .link_error_details);
    // ==========
    // tasks
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            failures++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic give_verdict;
        if (failures == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic rd(input logic [15:0] addr, input logic [15:0] exp);
        master.xfer(1'b0, 8'h01, addr, 16'h0000, 0, r);
        check("rdata", r.rdata, exp);
    endtask
    task automatic wr(input logic [7:0] slave, input logic [15:0] addr, input logic [15:0] d);
        master.xfer(1'b1, slave, addr, d, 0, r);
    endtask
    // ==========
    // sequence
    initial
    begin
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        rd(`DMBR_ADDR_TERM_IN, 16'h0055);
        rd(`DMBR_ADDR_DOUT_STAT, 16'h0005);
        for (int i = 0; i < 13; i++)
        begin
            @(posedge clk);
            drive <= dmbr_drive_s'(13'h0001 << (12 - i));
            rd(`DMBR_ADDR_DRIVE_STAT, (16'h0210 ^ (16'h0001 << stat_bit[i])) |
               (i == 12 ? 16'h4000 : 16'h0000));
        end
        @(posedge clk);
        drive <= '0;
        foreach (freq[k])
        begin
            @(posedge clk);
            output_frequency <= freq[k];
            rd(`DMBR_ADDR_DRIVE_STAT, fexp[k]);
        end
        foreach (mon_addr[k])
            rd(mon_addr[k], mon_val[k]);
        rd(16'h0030, 16'h0000);
        master.xfer(1'b1, 8'h01, `DMBR_ADDR_TERM_IN, 16'hffff, 3, r);
        check("code", {8'h00, r.code}, 16'h0022);
        check("error", {15'h0000, r.error}, 16'h0001);
        rd(`DMBR_ADDR_TERM_IN, 16'h0055);
        wr(8'h01, 16'h0050, 16'h1234);
        check("code", {8'h00, r.code}, 16'h0002);
        @(posedge clk);
        drive.operating <= 1'b1;
        link_err_event <= '{crc: 1'b1, timeout: 1'b1, default: 1'b0};
        @(posedge clk);
        link_err_event <= '0;
        rd(`DMBR_ADDR_LINK_ERR, 16'h0041);
        rd(`DMBR_ADDR_LINK_ERR, 16'h0041);
        @(posedge clk);
        local_fault_reset <= 1'b1;
        @(posedge clk);
        local_fault_reset <= 1'b0;
        rd(`DMBR_ADDR_LINK_ERR, 16'h0000);
        @(posedge clk);
        link_err_event.parity <= 1'b1;
        @(posedge clk);
        link_err_event <= '0;
        rd(`DMBR_ADDR_LINK_ERR, 16'h0008);
        wr(8'h00, `DMBR_ADDR_RUN_CMD, 16'h0020);
        check("resp_valid", {15'h0000, r.valid}, 16'h0000);
        check("link_err", link_error_details, 16'h0000);
        check("frst", {15'h0000, run.fault_reset}, 16'h0001);
        wr(8'h00, `DMBR_ADDR_RUN_CMD, 16'h0013);
        check("run", {12'h000, run.forward_run, run.reverse_run, run.external_fault,
              run.fault_reset}, 16'h000e);
        wr(8'h00, `DMBR_ADDR_SPEED_REF, 16'h1234);
        check("speed", speed_reference, 16'h1234);
        check("speed_ok", {15'h0000, speed_reference_valid}, 16'h0001);
        wr(8'h01, `DMBR_ADDR_SPEED_REF, 16'h0abc);
        check("resp_valid", {15'h0000, r.valid}, 16'h0001);
        check("code", {8'h00, r.code}, 16'h0000);
        check("speed", speed_reference, 16'h0abc);
        master.xfer(1'b0, 8'h00, `DMBR_ADDR_TERM_IN, 16'h0000, 0, r);
        check("resp_valid", {15'h0000, r.valid}, 16'h0000);
        @(posedge clk);
        input_terminal <= 7'h00;
        terminal_enable <= 3'b001;
        wr(8'h00, `DMBR_ADDR_RUN_CMD, 16'h7000);
        @(posedge clk);
        #1 check("terminals", {13'h0000, run.input_terminal_5_7}, 16'h0001);
        @(posedge clk);
        input_terminal <= 7'h60;
        repeat (2) @(posedge clk);
        #1 check("terminals", {13'h0000, run.input_terminal_5_7}, 16'h0007);
        @(posedge clk);
        input_terminal <= 7'h00;
        terminal_enable <= 3'b111;
        repeat (2) @(posedge clk);
        // rises sent while disabled must not have been taken
        #1 check("terminals", {13'h0000, run.input_terminal_5_7}, 16'h0001);
        wr(8'h00, `DMBR_ADDR_RUN_CMD, 16'h0000);
        @(posedge clk);
        #1 check("terminals", {13'h0000, run.input_terminal_5_7}, 16'h0000);
        give_verdict();
    end
    initial
    begin
        repeat (5000) @(posedge clk);
        failures++;
        give_verdict();
    end
endmodule
